// File: watchdog_map.svh
// register offsets, field positions, reset values and timing counts of the watchdog
// assumes inclusion by bare name from the design files
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH
`define WD_ADDR_W 16
`define WD_SERVICE_ADDR 16'h103A
`define WD_CONFIG_ADDR 16'h1039
`define WD_STATUS_ADDR 16'h1038
`define WD_KEY_FIRST 8'h55
`define WD_KEY_SECOND 8'hAA
`define WD_CNT_W 21
`define WD_RATE_LO 0
`define WD_RATE_HI 1
`define WD_RATE_RESET 2'h0
`define WD_EXP_BASE 15
`define WD_EXP_STEP 2
`define WD_VECTOR_NORMAL 16'hFFFE
`define WD_VECTOR_WATCHDOG 16'hFFFA
`define WD_RESET_PULSE 4'h4
`endif

// File: watchdog_pkg.sv
// types shared by the watchdog design files
// assumes watchdog_map.svh for the numbers
package watchdog_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED
    } key_state_t;
    typedef logic [1:0] rate_t;
endpackage

// File: watchdog_cfg_cell.sv
// nonvolatile disable cell: holds the disable bit, set by an external programming port
// assumes the programming port stands for an eeprom write path outside software reach
`timescale 1ns/1ps
`include "watchdog_map.svh"
module watchdog_cfg_cell (
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic prog_we,
    input wire logic prog_value,
    output logic disable_out
);
    // no reset on purpose: a power cycle or reset keeps the stored value
    logic cell_reg = 1'b0;
    always_ff @(posedge clk_sys) begin
        if (clk_en && prog_we) begin
            cell_reg <= prog_value;
        end
    end
    assign disable_out = cell_reg;
endmodule

// File: software_watchdog_timer.sv
// software watchdog: counts bus cycles, forces reset unless serviced by a two-key write
// assumes one clock, synchronous inputs and a one-cycle strobe register port
//
// Overview of operation
// - a timeout resets the system unless the stored nonvolatile disable bit is set.
// - in a special mode the disable bit may be overridden to block the hardware reset.
// - rate field 00,01,10,11 gives timeouts of 2^15, 2^17, 2^19 and 2^21 bus cycles.
// - both rate bits are zero after reset, giving the shortest timeout.
// - a write of 0x55 then 0xAA to the service register, or any write to the config register, restarts the watchdog.
// - any number of other bus cycles may fall between the two key writes.
// - reading the service register returns nothing useful and changes no state.
// - a watchdog reset is fetched through its own vector, apart from the normal one.
`timescale 1ns/1ps
`include "watchdog_map.svh"
module software_watchdog_timer (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic special_mode,
    input wire logic prog_we,
    input wire logic prog_value,
    output logic watchdog_reset,
    output logic [15:0] reset_vector
);
    localparam int CNT_W = `WD_CNT_W;

    logic watchdog_disable;
    logic [1:0] rate_reg;
    logic override_reg;
    logic [CNT_W-1:0] count_reg;
    watchdog_pkg::key_state_t key_reg;
    logic wd_cause_reg;
    logic [3:0] pulse_reg;
    logic timeout;
    logic service_done;
    logic enabled;

    // timeout count for a rate code
    function automatic logic [CNT_W-1:0] limit_of(input logic [1:0] rate);
        logic [4:0] exp_v;
        exp_v = 5'(`WD_EXP_BASE + `WD_EXP_STEP * int'(rate));
        limit_of = CNT_W'((22'h1 << exp_v) - 22'h1);
    endfunction

    watchdog_cfg_cell u_cfg (
        .clk_sys(clk_sys),
        .clk_en(clk_en),
        .prog_we(prog_we),
        .prog_value(prog_value),
        .disable_out(watchdog_disable)
    );

    wire wr_svc = wr_stb && (addr == `WD_SERVICE_ADDR);
    wire wr_cfg = wr_stb && (addr == `WD_CONFIG_ADDR);
    // override only counts in special mode, where it keeps timeouts from resetting
    assign enabled = !watchdog_disable && !(special_mode && override_reg);
    assign service_done = wr_svc && (wdata == `WD_KEY_SECOND)
                          && (key_reg == watchdog_pkg::KEY_ARMED);
    assign timeout = enabled && (count_reg == limit_of(rate_reg));

    // configuration: rate field and special-mode override bit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rate_reg <= `WD_RATE_RESET;
            override_reg <= 1'b0;
        end else if (clk_en && wr_cfg) begin
            rate_reg <= wdata[`WD_RATE_HI:`WD_RATE_LO];
            override_reg <= special_mode ? wdata[7] : 1'b0;
        end
    end

    // key sequence: reads never touch it; other cycles keep the armed state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            key_reg <= watchdog_pkg::KEY_IDLE;
        end else if (clk_en && wr_svc) begin
            case (key_reg)
                watchdog_pkg::KEY_IDLE: begin
                    if (wdata == `WD_KEY_FIRST) begin
                        key_reg <= watchdog_pkg::KEY_ARMED;
                    end
                end
                watchdog_pkg::KEY_ARMED: begin
                    // 0x55 again stays armed, anything else drops it
                    if (wdata == `WD_KEY_SECOND) begin
                        key_reg <= watchdog_pkg::KEY_IDLE;
                    end else if (wdata != `WD_KEY_FIRST) begin
                        key_reg <= watchdog_pkg::KEY_IDLE;
                    end
                end
                default: key_reg <= watchdog_pkg::KEY_IDLE;
            endcase
        end
    end

    // bus-cycle counter; a rate write restarts it so it never sits above a lower limit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (clk_en) begin
            if (service_done || timeout || !enabled || wr_cfg) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + CNT_W'(1);
            end
        end
    end

    // reset pulse and cause; cause survives the pulse so the vector stays selected
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pulse_reg <= 4'h0;
            wd_cause_reg <= 1'b0;
        end else if (clk_en) begin
            if (timeout) begin
                pulse_reg <= `WD_RESET_PULSE;
                wd_cause_reg <= 1'b1;
            end else if (pulse_reg != 4'h0) begin
                pulse_reg <= pulse_reg - 4'h1;
            end else if (wr_svc) begin
                wd_cause_reg <= 1'b0;
            end
        end
    end

    assign watchdog_reset = (pulse_reg != 4'h0);
    assign reset_vector = wd_cause_reg ? `WD_VECTOR_WATCHDOG : `WD_VECTOR_NORMAL;

    // read port: service register gives zero and changes nothing
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (clk_en && rd_stb) begin
            case (addr)
                `WD_CONFIG_ADDR: rdata <= {override_reg, 5'h00, rate_reg};
                `WD_STATUS_ADDR: rdata <= {4'h0, wd_cause_reg, watchdog_disable,
                                           enabled, key_reg == watchdog_pkg::KEY_ARMED};
                default: rdata <= 8'h00;
            endcase
        end
    end

    // checks
    svc_clears_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && service_done |=> count_reg == '0)
        else $error("counter not cleared by key sequence");
    timeout_resets_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && timeout |=> watchdog_reset [*4])
        else $error("timeout did not reset");
    disabled_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !enabled |-> !timeout)
        else $error("timeout while disabled");
    read_no_effect_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && rd_stb && !wr_stb |=> $stable(key_reg))
        else $error("read changed key state");
    vector_sel_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        watchdog_reset |-> reset_vector == `WD_VECTOR_WATCHDOG)
        else $error("wrong reset vector");
    shortest_limit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        timeout && rate_reg == 2'h0 |-> count_reg == 21'h007FFF)
        else $error("wrong timeout count");
    armed_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        key_reg == watchdog_pkg::KEY_ARMED && !wr_svc |=> key_reg == watchdog_pkg::KEY_ARMED)
        else $error("armed state lost");
    arm_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_svc && wdata == 8'h55 |=> key_reg == watchdog_pkg::KEY_ARMED)
        else $error("first key not taken");

    // special-mode override keeps the watchdog out of force
    override_blocks_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        special_mode && override_reg |-> !enabled)
        else $error("override did not block watchdog");

    // stored disable bit keeps the watchdog out of force
    disable_blocks_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        watchdog_disable |-> !enabled)
        else $error("disable bit ignored");

    // cleared cell outside special mode always runs the watchdog
    enabled_default_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !watchdog_disable && !special_mode |-> enabled)
        else $error("watchdog not running");

    // a disabled watchdog holds its counter at zero
    idle_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && !enabled |=> count_reg == '0)
        else $error("counter ran while disabled");

    // one count per enabled bus cycle
    count_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && enabled && !service_done && !timeout && !wr_cfg
        |=> count_reg == $past(count_reg) + CNT_W'(1))
        else $error("counter step wrong");

    // clock enable low freezes every piece of state
    freeze_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !clk_en |=> $stable(count_reg) && $stable(key_reg) && $stable(pulse_reg)
        && $stable(rate_reg))
        else $error("state moved while frozen");

    // counter never passes the selected limit
    count_below_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        count_reg <= limit_of(rate_reg))
        else $error("counter above limit");

    // any foreign value to the service register drops the sequence
    key_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_svc && wdata != 8'h55 && wdata != 8'hAA
        |=> key_reg == watchdog_pkg::KEY_IDLE)
        else $error("foreign key kept sequence");

    // a second key with no first key does not restart
    lone_second_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_svc && key_reg == watchdog_pkg::KEY_IDLE && enabled && !timeout
        |=> count_reg == $past(count_reg) + CNT_W'(1))
        else $error("lone second key restarted");

    // a finished sequence returns to idle
    disarm_after_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && service_done |=> key_reg == watchdog_pkg::KEY_IDLE)
        else $error("sequence not closed");

    // reset pulse ends when its count runs out
    pulse_end_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && pulse_reg == 4'h1 && !timeout |=> !watchdog_reset)
        else $error("reset pulse too long");

    // a timeout marks the watchdog as reset cause
    cause_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && timeout |=> wd_cause_reg)
        else $error("cause not recorded");

    // without a watchdog cause the normal vector is shown
    vector_normal_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !wd_cause_reg |-> reset_vector == `WD_VECTOR_NORMAL)
        else $error("wrong normal vector");

    // rate field moves only on a config write
    rate_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(clk_en && wr_cfg) |=> $stable(rate_reg))
        else $error("rate changed unasked");

    // a config write takes the rate bits
    rate_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_cfg |=> rate_reg == $past(wdata[`WD_RATE_HI:`WD_RATE_LO]))
        else $error("rate write lost");

    // a disabled watchdog never starts a reset pulse
    no_reset_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !enabled && !watchdog_reset |=> !watchdog_reset)
        else $error("reset while disabled");

    // reads do not disturb the count
    read_no_count_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && rd_stb && !wr_stb && enabled && !timeout
        |=> count_reg == $past(count_reg) + CNT_W'(1))
        else $error("read disturbed counter");

    // the service register reads as zero
    svc_read_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && rd_stb && addr == `WD_SERVICE_ADDR |=> rdata == 8'h00)
        else $error("service read not zero");

    // read data stand until the next read
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(clk_en && rd_stb) |=> $stable(rdata))
        else $error("read data moved");

    // the disable cell changes only through its programming port
    cell_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(clk_en && prog_we) |=> $stable(watchdog_disable))
        else $error("disable cell moved");

    // one timeout per period, the counter restarts at once
    timeout_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && timeout |=> !timeout)
        else $error("timeout repeated");

    // override cannot be set outside special mode
    override_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_cfg && !special_mode |=> !override_reg)
        else $error("override set in normal mode");

    // key state moves only on service writes
    key_steady_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && !wr_svc |=> key_reg == $past(key_reg))
        else $error("key state moved");

    // a service write after the pulse clears the cause
    cause_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        clk_en && wr_svc && !timeout && pulse_reg == 4'h0 |=> !wd_cause_reg)
        else $error("cause not cleared");
endmodule

// File: software_watchdog_timer_tb_top.sv
// bench for the software watchdog: register port, service keys, timeout, disable cell
// assumes the disable cell starts cleared; clock enable is dropped once to freeze the count
`timescale 1ns/1ps
module software_watchdog_timer_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic special_mode = 1'b0;
    logic prog_we = 1'b0;
    logic prog_value = 1'b0;
    logic clk_en = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic watchdog_reset;
    logic [15:0] reset_vector;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int t_svc;
    int hi;
    software_watchdog_timer i_dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .special_mode(special_mode), .prog_we(prog_we), .prog_value(prog_value),
        .watchdog_reset(watchdog_reset), .reset_vector(reset_vector));
    // 20 MHz system clock and a free cycle count
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end
    function automatic int timeout_cycles(input logic [1:0] rate);
        return 1 << (15 + 2 * rate);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // strobes last one cycle; a one-cycle gap follows each call
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard, well past the two timeout spans
    initial begin
        #(50 * 80000);
        bad_count++;
        give_verdict();
    end
    initial begin
        logic [7:0] r;
        logic [7:0] cfg_v;
        void'($urandom(32'hD828));
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk(reset_vector, 16'hFFFE, "normal vector");
        rd(16'h1039, r);
        chk(16'(r[1:0]), 16'h0000, "rate after reset");
        rd(16'h103A, r);
        chk(16'(r), 16'h0000, "service read");
        // random rate write outside special mode: override bit reads back zero
        cfg_v = 8'($urandom);
        wr(16'h1039, cfg_v);
        rd(16'h1039, r);
        chk(16'(r), 16'({6'h00, cfg_v[1:0]}), "rate readback");
        // override in special mode takes the watchdog out of force
        special_mode <= 1'b1;
        wr(16'h1039, 8'h80);
        rd(16'h1038, r);
        chk(16'(r[1]), 16'h0000, "override in special mode");
        special_mode <= 1'b0;
        rd(16'h1038, r);
        chk(16'(r[1]), 16'h0001, "override outside special mode");
        wr(16'h1039, 8'h00);
        wr(16'h103A, 8'h55);
        // unrelated traffic between keys, reads of the service place among it
        repeat (6) begin
            if ($urandom % 2) wr(16'h2000 + 16'($urandom % 256), 8'($urandom));
            else rd(16'h103A, r);
        end
        wr(16'h103A, 8'hAA);
        t_svc = cyc;
        // lone second key and a broken pair must not restart the count
        // 50 frozen cycles push the timeout back by as many
        repeat (1000) @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (50) @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (950) @(posedge clk_sys);
        wr(16'h103A, 8'hAA);
        wr(16'h103A, 8'h55);
        wr(16'h103A, 8'h13);
        wr(16'h103A, 8'hAA);
        while (cyc - t_svc < timeout_cycles(2'h0) + 60 && watchdog_reset !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        chk(16'(cyc - t_svc == timeout_cycles(2'h0) + 51 && watchdog_reset === 1'b1),
            16'h0001, "timeout moment");
        hi = 0;
        while (watchdog_reset === 1'b1 && hi < 10) begin
            hi++;
            @(posedge clk_sys);
            #1;
        end
        chk(16'(hi), 16'h0004, "reset pulse length");
        chk(reset_vector, 16'hFFFA, "watchdog vector");
        // disable cell set; special mode without override keeps it in force
        @(posedge clk_sys);
        special_mode <= 1'b1;
        prog_we <= 1'b1;
        prog_value <= 1'b1;
        @(posedge clk_sys);
        prog_we <= 1'b0;
        wr(16'h103A, 8'h55);
        wr(16'h103A, 8'hAA);
        hi = 0;
        repeat (timeout_cycles(2'h0) + 40) begin
            @(posedge clk_sys);
            #1;
            if (watchdog_reset !== 1'b0) hi++;
        end
        chk(16'(hi), 16'h0000, "disabled watchdog fired");
        give_verdict();
    end
endmodule
